/* include/ppd_defines.vh */
// constants, register map and field positions for the port pin drive block
`ifndef PPD_DEFINES_VH
`define PPD_DEFINES_VH

// ----------------------------------------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define PPD_ADDR_W 3
`define PPD_IDX_OUT 3'h0
`define PPD_IDX_DIR 3'h1
`define PPD_IDX_ANA 3'h2
`define PPD_IDX_CHAN 3'h3
`define PPD_IDX_PERI 3'h4
`define PPD_IDX_MISC 3'h5
`define PPD_IDX_PIN_IN 3'h6

// ----------------------------------------------------------------------
// field positions in the misc register
// ----------------------------------------------------------------------
`define PPD_MISC_SO_OD 0
`define PPD_MISC_PULLUP 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
// per-bit reset levels, replicated to each register's own width
`define PPD_OUT_RST_BIT 1'b1
`define PPD_ZERO_RST_BIT 1'b0
`define PPD_RDATA_UNMAPPED 32'h00000000

`endif

/* core/ppd_pin_cell.v */
// one pin's buffer enable decode
`timescale 1ns/1ps
module ppd_pin_cell
(
  input wire dir,
  input wire dout,
  input wire analog_sel,
  input wire periph_sel,
  input wire periph_oe,
  input wire periph_do,
  input wire pullup_glb,
  input wire nmos_od,
  input wire pmos_od,
  input wire med_volt,
  output wire pmos_en,
  output wire nmos_en,
  output wire pullup_en
);
  // effective direction and value: peripheral wins over port
  wire eff_out = periph_sel ? periph_oe : dir;
  wire eff_val = periph_sel ? periph_do : dout;
  // analog selection kills both drivers in every case
  wire drive = eff_out & ~analog_sel;
  // open-drain styles suppress one transistor
  assign pmos_en = drive & eff_val & ~nmos_od & ~med_volt;
  assign nmos_en = drive & ~eff_val & ~pmos_od;
  // pull-up follows only global enable and port data
  // medium-voltage pins have no pull-up device
  assign pullup_en = pullup_glb & dout & ~med_volt;
endmodule

/* core/ppd_port_ctl.v */
// register file and per-pin drive control for the general purpose port
`timescale 1ns/1ps
`include "ppd_defines.vh"
module ppd_port_ctl
#(
  parameter NPINS = 16,
  parameter CHAN_W = 4,
  parameter SO_PIN = 2,
  parameter ALARM_PIN = 3,
  parameter [NPINS-1:0] MED_VOLT_MASK = 16'h0000
)
(
  input wire clk,
  input wire reset,
  // stop-mode system reset request
  input wire stop_reset,
  // avalon-mm slave
  input wire [`PPD_ADDR_W+1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // peripheral side
  input wire [NPINS-1:0] periph_oe,
  input wire [NPINS-1:0] periph_do,
  // pin side
  input wire [NPINS-1:0] pin_in,
  output wire [NPINS-1:0] pmos_en,
  output wire [NPINS-1:0] nmos_en,
  output wire [NPINS-1:0] pullup_en,
  output wire [NPINS-1:0] pin_to_periph,
  output wire [CHAN_W-1:0] analog_channel_sel
);
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg [NPINS-1:0] pin_output_value_reg; // port output data
  reg [NPINS-1:0] pin_direction_ctl_reg; // 1 = output
  reg [NPINS-1:0] analog_select_reg; // 1 = analog input
  reg [NPINS-1:0] port_mode_sel_reg; // 1 = peripheral owns pin
  reg [CHAN_W-1:0] analog_channel_sel_reg; // converter channel
  reg serial_out_open_drain_sel_reg; // so pin nmos open drain
  reg global_pullup_enable_reg; // pull-ups globally on
  reg ack_reg; // one-cycle wait answer
  // three-stage pin synchroniser
  reg [NPINS-1:0] sync1_reg;
  reg [NPINS-1:0] sync2_reg;
  reg [NPINS-1:0] sync3_reg;
  reg [NPINS-1:0] pin_state_reg;

  wire [`PPD_ADDR_W-1:0] idx = avs_address[`PPD_ADDR_W+1:2];
  wire any_req = avs_read | avs_write;
  wire wr_fire = avs_write & ack_reg;
  wire [31:0] bmask;
  // either reset clears the registers, output data excepted (set to ones), but the input synchroniser clears on reset only; stop mode acts as system reset
  wire sys_rst = reset | stop_reset;

  // byte-enable mask
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1)
    begin : g_be
      assign bmask[b*8+7:b*8] = {8{avs_byteenable[b]}};
    end
  endgenerate

  // merge write data into an old value under byte enables
  // sized to the pin count, so write-data bits above the pin count are dropped
  function [NPINS-1:0] merge;
    input [NPINS-1:0] old;
    input [NPINS-1:0] wd;
    input [NPINS-1:0] m;
    begin
      merge = (old & ~m) | (wd & m);
    end
  endfunction

  // ----------------------------------------------------------------------
  // bus handshake: waitrequest low on the second cycle of each request
  // ----------------------------------------------------------------------
  // one wait state keeps read data registered
  always @(posedge clk)
  begin
    if (sys_rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= any_req & ~ack_reg;
  end
  assign avs_waitrequest = any_req & ~ack_reg;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_output_value_reg <= {NPINS{`PPD_OUT_RST_BIT}};
      // direction zero floats every pin
      pin_direction_ctl_reg <= {NPINS{`PPD_ZERO_RST_BIT}};
      analog_select_reg <= {NPINS{`PPD_ZERO_RST_BIT}};
      port_mode_sel_reg <= {NPINS{`PPD_ZERO_RST_BIT}};
      analog_channel_sel_reg <= {CHAN_W{`PPD_ZERO_RST_BIT}};
      serial_out_open_drain_sel_reg <= 1'b0;
      global_pullup_enable_reg <= 1'b0;
    end
    else if (wr_fire)
    begin
      case (idx)
        `PPD_IDX_OUT:
          pin_output_value_reg <= merge(pin_output_value_reg,
            avs_writedata[NPINS-1:0], bmask[NPINS-1:0]);
        `PPD_IDX_DIR:
          // per-pin direction select
          pin_direction_ctl_reg <= merge(pin_direction_ctl_reg,
            avs_writedata[NPINS-1:0], bmask[NPINS-1:0]);
        `PPD_IDX_ANA:
          analog_select_reg <= merge(analog_select_reg,
            avs_writedata[NPINS-1:0], bmask[NPINS-1:0]);
        `PPD_IDX_CHAN:
        begin
          // channel routed to the converter; field sits in byte 0
          if (avs_byteenable[0])
            analog_channel_sel_reg <= avs_writedata[CHAN_W-1:0];
        end
        `PPD_IDX_PERI:
          // port or peripheral use per shared pin
          port_mode_sel_reg <= merge(port_mode_sel_reg,
            avs_writedata[NPINS-1:0], bmask[NPINS-1:0]);
        `PPD_IDX_MISC:
        begin
          if (avs_byteenable[0])
          begin
            serial_out_open_drain_sel_reg <=
              avs_writedata[`PPD_MISC_SO_OD];
            global_pullup_enable_reg <= avs_writedata[`PPD_MISC_PULLUP];
          end
        end
        default:
        begin
          // unmapped or read-only word: write ignored
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read data, registered at the acknowledge edge
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (sys_rst)
      avs_readdata <= `PPD_RDATA_UNMAPPED;
    else if (avs_read & ~ack_reg)
    begin
      case (idx)
        `PPD_IDX_OUT:
          avs_readdata <= {{(32-NPINS){1'b0}}, pin_output_value_reg};
        `PPD_IDX_DIR:
          avs_readdata <= {{(32-NPINS){1'b0}}, pin_direction_ctl_reg};
        `PPD_IDX_ANA:
          avs_readdata <= {{(32-NPINS){1'b0}}, analog_select_reg};
        `PPD_IDX_CHAN:
          avs_readdata <= {{(32-CHAN_W){1'b0}}, analog_channel_sel_reg};
        `PPD_IDX_PERI:
          avs_readdata <= {{(32-NPINS){1'b0}}, port_mode_sel_reg};
        `PPD_IDX_MISC:
          avs_readdata <= {30'h0, global_pullup_enable_reg,
            serial_out_open_drain_sel_reg};
        `PPD_IDX_PIN_IN:
          avs_readdata <= {{(32-NPINS){1'b0}}, pin_state_reg};
        default: avs_readdata <= `PPD_RDATA_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pin input synchroniser; a change counts when stages two and three agree
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      sync1_reg <= {NPINS{1'b0}};
      sync2_reg <= {NPINS{1'b0}};
      sync3_reg <= {NPINS{1'b0}};
      pin_state_reg <= {NPINS{1'b0}};
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // bits where stages disagree keep their last settled value
      // agreeing bits take stage three, so a pin can fall as well as rise
      pin_state_reg <= (sync3_reg & ~(sync2_reg ^ sync3_reg))
        | (pin_state_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // analog pins deliver no digital level to a peripheral
  assign pin_to_periph = pin_state_reg & port_mode_sel_reg
    & ~analog_select_reg;
  assign analog_channel_sel = analog_channel_sel_reg;

  // ----------------------------------------------------------------------
  // per-pin buffer decode
  // ----------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NPINS; p = p + 1)
    begin : g_pin
      ppd_pin_cell u_cell
      (
        .dir(pin_direction_ctl_reg[p]),
        .dout(pin_output_value_reg[p]),
        .analog_sel(analog_select_reg[p]),
        .periph_sel(port_mode_sel_reg[p]),
        .periph_oe(periph_oe[p]),
        .periph_do(periph_do[p]),
        .pullup_glb(global_pullup_enable_reg),
        // so pin open drain in port and peripheral use alike
        .nmos_od((p == SO_PIN) ? serial_out_open_drain_sel_reg : 1'b0),
        // alarm output is pmos-only when a peripheral drives it
        .pmos_od((p == ALARM_PIN) ? port_mode_sel_reg[p] : 1'b0),
        .med_volt(MED_VOLT_MASK[p]),
        .pmos_en(pmos_en[p]),
        .nmos_en(nmos_en[p]),
        .pullup_en(pullup_en[p])
      );
    end
  endgenerate
endmodule

/* tb/ppd_port_ctl_checker.sv */
// port-level assertions for the port pin drive block
`timescale 1ns/1ps
`include "ppd_defines.vh"
module ppd_port_ctl_checker
#(
  parameter NPINS = 16,
  parameter [NPINS-1:0] MED_VOLT_MASK = 16'h0000
)
(
  input wire clk,
  input wire reset,
  input wire stop_reset,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  input wire [NPINS-1:0] periph_oe,
  input wire [NPINS-1:0] periph_do,
  input wire [NPINS-1:0] pmos_en,
  input wire [NPINS-1:0] nmos_en,
  input wire [NPINS-1:0] pullup_en,
  input wire [3:0] analog_channel_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a write that lands this edge may move the enables
  wire wr_done = avs_write && !avs_waitrequest;
  property p_wait1;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait1: assert property (p_wait1) else $error("wait too long");
  property p_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("idle wait");
  property p_excl;
    (pmos_en & nmos_en) == 0;
  endproperty
  a_excl: assert property (p_excl) else $error("both drivers on");
  property p_mv;
    ((pmos_en | pullup_en) & MED_VOLT_MASK) == 0;
  endproperty
  a_mv: assert property (p_mv) else $error("mv pin pulled high");
  property p_stop;
    stop_reset |=> pmos_en == 0 && nmos_en == 0 && pullup_en == 0;
  endproperty
  a_stop: assert property (p_stop) else $error("pins not floated");
  property p_chan;
    stop_reset |=> analog_channel_sel == 4'h0;
  endproperty
  a_chan: assert property (p_chan) else $error("channel kept");
  property p_pull;
    !wr_done && !stop_reset |=> $stable(pullup_en);
  endproperty
  a_pull: assert property (p_pull) else $error("pullup moved");
  // peripheral inputs may also move drive enables
  property p_drv;
    !wr_done && !stop_reset ##1 $stable(periph_oe) && $stable(periph_do)
      |-> $stable(pmos_en) && $stable(nmos_en);
  endproperty
  a_drv: assert property (p_drv) else $error("drive moved");
  property p_rd;
    !avs_read && !stop_reset |=> $stable(avs_readdata);
  endproperty
  a_rd: assert property (p_rd) else $error("readdata moved");
  c_rd: cover property (avs_read && !avs_waitrequest);
  c_wr: cover property (wr_done);
  c_stop: cover property (stop_reset);
endmodule
bind ppd_port_ctl ppd_port_ctl_checker #(.NPINS(NPINS),
  .MED_VOLT_MASK(MED_VOLT_MASK)) i_ppd_port_ctl_checker (.*);

/* tb/ppd_pin_model.sv */
// board pins: resolves buffer enables into pin levels
`timescale 1ns/1ps
module ppd_pin_model
(
  input wire clk,
  input wire [15:0] pmos_en,
  input wire [15:0] nmos_en,
  input wire [15:0] pullup_en,
  output wire [15:0] pin_lvl
);
  // a floating pin shows a changing level, never a held one
  logic [15:0] flt_reg = 16'h0000;
  always @(posedge clk)
  begin
    flt_reg <= ~flt_reg;
  end
  // nmos wins, then pmos or pull-up, else floating
  assign pin_lvl = ~nmos_en & (pmos_en | pullup_en | flt_reg);
endmodule

/* tb/port_pin_drive_control_tb.sv */
// self-checking bench for the port pin drive block
`timescale 1ns/1ps
module port_pin_drive_control_tb;
  localparam [15:0] MV = 16'h0030; // medium-voltage pins 4 and 5
  logic clk, reset, stop_reset, rd, wr;
  logic [4:0] adr;
  logic [31:0] wd, rdata, rdv;
  logic [3:0] be, chan;
  logic wreq;
  logic [15:0] poe, pdo, pin, pe, ne, ue, p2p;
  int errors = 0;
  int num_checks = 0;
  ppd_port_ctl #(.MED_VOLT_MASK(MV)) i_ppd_port_ctl (.clk(clk),
    .reset(reset), .stop_reset(stop_reset), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .periph_oe(poe), .periph_do(pdo), .pin_in(pin), .pmos_en(pe),
    .nmos_en(ne), .pullup_en(ue), .pin_to_periph(p2p),
    .analog_channel_sel(chan));
  ppd_pin_model i_ppd_pin_model (.clk(clk), .pmos_en(pe), .nmos_en(ne),
    .pullup_en(ue), .pin_lvl(pin));
  task final_report;
  begin
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] s, input [31:0] e);
  begin
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  end
  endtask
  // one avalon transfer; request held until waitrequest is low
  task bus(input w, input [2:0] i, input [31:0] d);
    int k;
  begin
    adr <= {i, 2'b00};
    wd <= d;
    wr <= w;
    rd <= !w;
    k = 0;
    @(posedge clk);
    while (wreq !== 1'b0)
    begin
      k++;
      if (k > 20)
      begin
        errors++;
        final_report;
      end
      @(posedge clk);
    end
    rdv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  end
  endtask
  // compare settled enables, then return on a rising edge
  task pins(input [15:0] p, input [15:0] n, input [15:0] u);
  begin
    @(negedge clk);
    chk(pe, p);
    chk(ne, n);
    chk(ue, u);
    @(posedge clk);
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    reset = 1'b1;
    stop_reset = 1'b0;
    {rd, wr, adr, wd, poe, pdo} = '0;
    be = 4'hf;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(0, 0, 0); chk(rdv, 32'h0000ffff);
    pins(0, 0, 0);
    bus(1, 1, 32'h00ff); // pins 8..15 stay as reset left them
    bus(1, 0, 32'h00ae);
    pins(16'h00ae & ~MV, 16'h0051, 0);
    bus(1, 5, 32'h2);
    pins(16'h008e, 16'h0051, 16'h008e);
    bus(1, 5, 32'h3);
    pins(16'h008a, 16'h0051, 16'h008e);
    bus(1, 2, 32'h00c3);
    pins(16'h0008, 16'h0010, 16'h008e);
    bus(1, 0, 32'h002e); // clear data before analog use
    pins(16'h0008, 16'h0010, 16'h000e);
    bus(1, 3, 32'ha); chk(chan, 4'ha);
    bus(1, 2, 0);
    poe <= 16'h0009;
    pdo <= 16'h0001;
    bus(1, 4, 32'h0009);
    pins(16'h0003, 16'h00d0, 16'h000e);
    pdo <= 16'h0008;
    pins(16'h000a, 16'h00d1, 16'h000e);
    repeat (6) @(posedge clk);
    chk(p2p, 16'h0008);
    stop_reset <= 1'b1;
    @(posedge clk);
    stop_reset <= 1'b0;
    pins(0, 0, 0);
    chk(chan, 4'h0);
    bus(0, 4, 0); chk(rdv, 0);
    bus(0, 0, 0); chk(rdv, 32'h0000ffff);
    bus(1, 7, 32'h5a5a5a5a);
    bus(0, 7, 0); chk(rdv, 0);
    final_report;
  end
endmodule
